// file: core/usb_dma_engine.sv
// USB DMA engine: transmit queue with teardown, receive descriptor chain walker, register file.
//
// What this block does
// - Teardown stops the running transmit and empties the channel's queue.
// - The teardown register shows ready only when a teardown can be accepted.
// - Finished teardown raises the channel interrupt and loads completion pointer 0xFFFFFFC.
// - Receive buffers are contiguous, byte aligned, 1 to 65,535 bytes long.
// - Receive descriptors are four 32-bit words at a word-aligned address.
// - Packet edges come from start and end flags; a zero link ends the queue.
// - Word 0 holds the word-aligned next-descriptor address, written by software.
// - Word 1 holds the byte-aligned buffer address used as the write target.
// - On a start descriptor the engine writes the channel's receive offset into word 2.
// - The word 2 length counts valid data bytes only, leading offset excluded.
// - On an end descriptor a short fill replaces the length with the received count.
// - On a start descriptor length is rewritten for nonzero offset or short packet.
// - Ownership and packet length live in start descriptors, end-of-queue in end ones.
// - After a transmitted packet the engine clears ownership in its start descriptor.
`timescale 1ns/1ps
`default_nettype none
`include "usb_dma_map.svh"

module usb_dma_engine
  import usb_dma_pkg::*;
#(
  parameter int TX_CH_ID = 0
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output mem_req_s mem_req,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output tx_xfer_s tx_xfer,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_dma_irq,
  output logic rx_dma_irq
);

  // The channel field is two bits wide, so only four channel numbers exist.
  if (TX_CH_ID < 0 || TX_CH_ID > 3) begin : g_bad_ch
    $error("TX_CH_ID must lie in 0 to 3");
  end

  eng_s s_reg;
  eng_s s_next;
  reg_wr_s reg_wr;
  logic [31:0] rd_data;
  logic [31:0] lane_wdata;
  logic [3:0] lane_wstrb;

  axil_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rd_data(rd_data),
    .reg_wr(reg_wr)
  );

  byte_lane u_lane (
    .lane(s_reg.wptr[1:0]),
    .data_byte(rx_byte),
    .wdata(lane_wdata),
    .wstrb(lane_wstrb)
  );

  // Applies AXI byte strobes to a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = val[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Read mux; offsets outside the map read as zero.
  always_comb begin
    rd_data = '0;
    case (s_axi_araddr)
      `REG_CTRL_OFS: begin
        rd_data[`CTRL_TX_EN_BIT] = s_reg.tx_en;
        rd_data[`CTRL_RX_EN_BIT] = s_reg.rx_en;
        rd_data[`CTRL_LPSM_BIT] = s_reg.lpsm;
      end
      `REG_TX_HEAD_OFS: rd_data = s_reg.tx_head;
      `REG_TX_COMP_OFS: rd_data = s_reg.tx_comp;
      `REG_TEARDOWN_OFS: rd_data[`TD_READY_BIT] = !s_reg.td_pend;
      `REG_RX_HEAD_OFS: rd_data = s_reg.rx_head;
      `REG_RX_COMP_OFS: rd_data = s_reg.rx_comp;
      `REG_RX_OFFSET_OFS: rd_data[15:0] = s_reg.rx_offset;
      `REG_STATUS_OFS: begin
        rd_data[`STAT_TX_IRQ_BIT] = s_reg.tx_irq;
        rd_data[`STAT_RX_IRQ_BIT] = s_reg.rx_irq;
        rd_data[`STAT_BUSY_BIT] = (s_reg.st != ST_IDLE);
      end
      default: rd_data = '0;
    endcase
  end

  // Register writes first, then the sequencer, so a hardware set in the same cycle wins over a clear.
  always_comb begin
    logic [31:0] wval;
    logic [31:0] w3;
    logic do_td;
    logic finish;
    logic fetch;
    wval = '0;
    w3 = '0;
    do_td = 1'b0;
    finish = 1'b0;
    fetch = 1'b0;
    s_next = s_reg;
    if (s_reg.mem.valid && mem_ack) begin
      s_next.mem.valid = 1'b0;
    end
    if (reg_wr.valid) begin
      case (reg_wr.addr)
        `REG_CTRL_OFS: begin
          wval = merge({29'h0, s_reg.lpsm, s_reg.rx_en, s_reg.tx_en}, reg_wr.data, reg_wr.strb);
          s_next.tx_en = wval[`CTRL_TX_EN_BIT];
          s_next.rx_en = wval[`CTRL_RX_EN_BIT];
          s_next.lpsm = wval[`CTRL_LPSM_BIT];
        end
        `REG_TX_HEAD_OFS: s_next.tx_head = merge(s_reg.tx_head, reg_wr.data, reg_wr.strb);
        `REG_TX_COMP_OFS: begin
          // An acknowledge that matches the stored pointer drops the interrupt.
          if (merge(s_reg.tx_comp, reg_wr.data, reg_wr.strb) == s_reg.tx_comp) begin
            s_next.tx_irq = 1'b0;
          end
        end
        `REG_TEARDOWN_OFS: begin
          if (!s_reg.td_pend && reg_wr.data[`TD_CHAN_MSB:`TD_CHAN_LSB] == 2'(TX_CH_ID)) begin
            s_next.td_pend = 1'b1;
          end
        end
        `REG_RX_HEAD_OFS: s_next.rx_head = merge(s_reg.rx_head, reg_wr.data, reg_wr.strb);
        `REG_RX_COMP_OFS: begin
          if (merge(s_reg.rx_comp, reg_wr.data, reg_wr.strb) == s_reg.rx_comp) begin
            s_next.rx_irq = 1'b0;
          end
        end
        `REG_RX_OFFSET_OFS: begin
          wval = merge({16'h0, s_reg.rx_offset}, reg_wr.data, reg_wr.strb);
          s_next.rx_offset = wval[15:0];
        end
        default: s_next.st = s_reg.st;
      endcase
    end

    // Sequencer.
    unique case (s_reg.st)
      ST_IDLE: begin
        if (s_reg.td_pend) begin
          do_td = 1'b1;
        end else if (s_reg.tx_en && s_reg.tx_head != `RST_WORD) begin
          s_next.cur = s_reg.tx_head;
          s_next.is_tx = 1'b1;
          fetch = 1'b1;
        end else if (s_reg.rx_en && s_reg.rx_head != `RST_WORD && rx_valid) begin
          s_next.cur = s_reg.rx_head;
          s_next.is_tx = 1'b0;
          fetch = 1'b1;
        end
      end
      ST_FETCH: begin
        // Four words are read in order from the word-aligned descriptor address.
        if (s_reg.mem.valid && mem_ack) begin
          s_next.desc[s_reg.widx] = mem_rdata;
          if (s_reg.widx != 2'h3) begin
            s_next.widx = s_reg.widx + 2'h1;
            s_next.mem.valid = 1'b1;
            s_next.mem.addr = s_reg.cur + {28'h0, s_reg.widx + 2'h1, 2'h0};
          end else if (s_reg.is_tx) begin
            if (s_reg.td_pend) begin
              do_td = 1'b1;
            end else if (!mem_rdata[`DESC_OWN_BIT] || !mem_rdata[`DESC_SOP_BIT] || !mem_rdata[`DESC_EOP_BIT]) begin
              // A descriptor not handed over as a one-buffer packet stops the queue.
              s_next.tx_head = `RST_WORD;
              s_next.st = ST_IDLE;
            end else begin
              s_next.xfer.valid = 1'b1;
              s_next.xfer.addr = s_reg.desc[1] + {16'h0, s_reg.desc[2][`DESC_OFS_MSB:`DESC_OFS_LSB]};
              s_next.xfer.len = s_reg.desc[2][`DESC_LEN_MSB:`DESC_LEN_LSB];
              s_next.st = ST_TX_XFER;
            end
          end else begin
            // Data lands after the offset on a start buffer only; length counts data alone.
            s_next.wptr = s_reg.desc[1] + (s_reg.sop ? {16'h0, s_reg.rx_offset} : `RST_WORD);
            s_next.cap = s_reg.desc[2][`DESC_LEN_MSB:`DESC_LEN_LSB] - (s_reg.sop ? s_reg.rx_offset : `RST_HALF);
            s_next.cnt = `RST_HALF;
            s_next.rx_ready = 1'b1;
            s_next.st = ST_RX_DATA;
          end
        end
      end
      ST_TX_XFER: begin
        if (s_reg.td_pend) begin
          s_next.xfer.valid = 1'b0;
          do_td = 1'b1;
        end else if (tx_done) begin
          s_next.xfer.valid = 1'b0;
          w3 = s_reg.desc[3];
          w3[`DESC_OWN_BIT] = 1'b0;
          w3[`DESC_EOQ_BIT] = (s_reg.desc[0] == `RST_WORD);
          s_next.mem = '{valid: 1'b1, we: 1'b1, addr: s_reg.cur + 32'h0000000C, wdata: w3, wstrb: 4'hF};
          s_next.st = ST_TX_WB;
        end
      end
      ST_TX_WB: begin
        if (mem_ack) begin
          s_next.tx_comp = s_reg.cur;
          s_next.tx_irq = 1'b1;
          s_next.tx_head = s_reg.desc[0];
          s_next.st = ST_IDLE;
        end
      end
      ST_RX_DATA: begin
        if (rx_valid && s_reg.rx_ready) begin
          s_next.rx_ready = 1'b0;
          s_next.mem = '{valid: 1'b1, we: 1'b1, addr: s_reg.wptr, wdata: lane_wdata, wstrb: lane_wstrb};
          s_next.last = rx_last;
          s_next.cnt = s_reg.cnt + 16'h1;
          s_next.pkt_cnt = s_reg.pkt_cnt + 16'h1;
          s_next.wptr = s_reg.wptr + 32'h1;
          s_next.st = ST_RX_WR;
        end
      end
      ST_RX_WR: begin
        if (mem_ack) begin
          if (s_reg.last || s_reg.cnt == s_reg.cap) begin
            // Word 2 carries the real offset and the bytes actually stored.
            s_next.mem = '{valid: 1'b1, we: 1'b1, addr: s_reg.cur + 32'h00000008,
                           wdata: {(s_reg.sop ? s_reg.rx_offset : `RST_HALF), s_reg.cnt},
                           wstrb: 4'hF};
            s_next.st = ST_RX_WB2;
          end else begin
            s_next.rx_ready = 1'b1;
            s_next.st = ST_RX_DATA;
          end
        end
      end
      ST_RX_WB2: begin
        if (mem_ack) begin
          if (s_reg.last) begin
            // End descriptor gets its flags; a lone buffer also carries the start fields.
            w3 = s_reg.desc[3];
            w3[`DESC_SOP_BIT] = s_reg.sop;
            w3[`DESC_EOP_BIT] = 1'b1;
            w3[`DESC_EOQ_BIT] = (s_reg.desc[0] == `RST_WORD);
            if (s_reg.sop) begin
              w3[`DESC_OWN_BIT] = 1'b0;
              w3[`DESC_LEN_MSB:`DESC_LEN_LSB] = s_reg.pkt_cnt;
            end
            s_next.mem = '{valid: 1'b1, we: 1'b1, addr: s_reg.cur + 32'h0000000C, wdata: w3, wstrb: 4'hF};
            s_next.st = ST_RX_WB3E;
          end else begin
            if (s_reg.sop) begin
              s_next.sop_addr = s_reg.cur;
              s_next.sop_w3 = s_reg.desc[3];
            end
            s_next.sop = 1'b0;
            // A zero link here means the queue ran out in mid-packet; the engine parks.
            if (s_reg.desc[0] == `RST_WORD) begin
              s_next.rx_head = `RST_WORD;
              s_next.st = ST_IDLE;
            end else begin
              s_next.rx_head = s_reg.desc[0];
              s_next.cur = s_reg.desc[0];
              s_next.is_tx = 1'b0;
              fetch = 1'b1;
            end
          end
        end
      end
      ST_RX_WB3E: begin
        if (mem_ack) begin
          if (s_reg.sop) begin
            finish = 1'b1;
          end else begin
            w3 = s_reg.sop_w3;
            w3[`DESC_SOP_BIT] = 1'b1;
            w3[`DESC_EOP_BIT] = 1'b0;
            w3[`DESC_OWN_BIT] = 1'b0;
            w3[`DESC_LEN_MSB:`DESC_LEN_LSB] = s_reg.pkt_cnt;
            s_next.mem = '{valid: 1'b1, we: 1'b1, addr: s_reg.sop_addr + 32'h0000000C, wdata: w3, wstrb: 4'hF};
            s_next.st = ST_RX_WB3S;
          end
        end
      end
      ST_RX_WB3S: begin
        if (mem_ack) begin
          finish = 1'b1;
        end
      end
    endcase

    // Start of a four-word descriptor read.
    if (fetch) begin
      s_next.widx = 2'h0;
      s_next.mem = '{valid: 1'b1, we: 1'b0, addr: s_next.cur, wdata: `RST_WORD, wstrb: 4'h0};
      s_next.st = ST_FETCH;
    end
    // Packet received: report the end descriptor and move to the next packet.
    if (finish) begin
      s_next.rx_comp = s_reg.cur;
      s_next.rx_irq = 1'b1;
      s_next.rx_head = s_reg.desc[0];
      s_next.sop = 1'b1;
      s_next.pkt_cnt = `RST_HALF;
      s_next.st = ST_IDLE;
    end
    // Teardown drops the whole queue and leaves the reclaim marker behind.
    if (do_td) begin
      s_next.tx_head = `RST_WORD;
      s_next.tx_comp = `TD_DONE_PTR;
      s_next.tx_irq = 1'b1;
      s_next.td_pend = 1'b0;
      s_next.st = ST_IDLE;
    end
  end

  // State register; the segmentation mode bit is only stored, single-descriptor mode is what runs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.sop <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign mem_req = s_reg.mem;
  assign tx_xfer = s_reg.xfer;
  assign rx_ready = s_reg.rx_ready;
  assign tx_dma_irq = s_reg.tx_irq;
  assign rx_dma_irq = s_reg.rx_irq;

endmodule
`default_nettype wire

// file: core/usb_dma_map.svh
// Register offsets, field positions, reset values and descriptor layout of the USB DMA engine.
`ifndef USB_DMA_MAP_SVH
`define USB_DMA_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define REG_CTRL_OFS 8'h00
`define REG_TX_HEAD_OFS 8'h04
`define REG_TX_COMP_OFS 8'h08
`define REG_TEARDOWN_OFS 8'h0C
`define REG_RX_HEAD_OFS 8'h10
`define REG_RX_COMP_OFS 8'h14
`define REG_RX_OFFSET_OFS 8'h18
`define REG_STATUS_OFS 8'h1C

// Control register fields.
`define CTRL_TX_EN_BIT 0
`define CTRL_RX_EN_BIT 1
`define CTRL_LPSM_BIT 2

// Teardown register fields.
`define TD_READY_BIT 31
`define TD_CHAN_MSB 1
`define TD_CHAN_LSB 0

// Status register fields.
`define STAT_TX_IRQ_BIT 0
`define STAT_RX_IRQ_BIT 1
`define STAT_BUSY_BIT 2

// Descriptor word 3 flags and field split of word 2.
`define DESC_SOP_BIT 31
`define DESC_EOP_BIT 30
`define DESC_OWN_BIT 29
`define DESC_EOQ_BIT 28
`define DESC_OFS_MSB 31
`define DESC_OFS_LSB 16
`define DESC_LEN_MSB 15
`define DESC_LEN_LSB 0

// Completion pointer value left behind by a finished teardown.
`define TD_DONE_PTR 32'h0FFFFFFC

// Reset values.
`define RST_WORD 32'h00000000
`define RST_HALF 16'h0000

`endif

// file: core/usb_dma_pkg.sv
// Types shared by the USB DMA engine modules.
package usb_dma_pkg;

  // Engine sequencer states, one-hot.
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_FETCH   = 9'h002,
    ST_TX_XFER = 9'h004,
    ST_TX_WB   = 9'h008,
    ST_RX_DATA = 9'h010,
    ST_RX_WR   = 9'h020,
    ST_RX_WB2  = 9'h040,
    ST_RX_WB3E = 9'h080,
    ST_RX_WB3S = 9'h100
  } eng_state_e;

  // Word request to main memory; held until acknowledged.
  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } mem_req_s;

  // Transmit buffer handed to the endpoint FIFO mover.
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [15:0] len;
  } tx_xfer_s;

  // Register write strobe from the bus front end.
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } reg_wr_s;

  // Bus front-end state.
  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    logic bvalid;
    logic rvalid;
    logic [31:0] rdata;
    reg_wr_s wr;
  } axil_s;

  // Engine state.
  typedef struct packed {
    eng_state_e st;
    logic tx_en;
    logic rx_en;
    logic lpsm;
    logic [31:0] tx_head;
    logic [31:0] tx_comp;
    logic [31:0] rx_head;
    logic [31:0] rx_comp;
    logic [15:0] rx_offset;
    logic td_pend;
    logic tx_irq;
    logic rx_irq;
    logic is_tx;
    logic [1:0] widx;
    logic [3:0][31:0] desc;
    logic [31:0] cur;
    logic [31:0] sop_addr;
    logic [31:0] sop_w3;
    logic [31:0] wptr;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [15:0] pkt_cnt;
    logic sop;
    logic last;
    logic rx_ready;
    mem_req_s mem;
    tx_xfer_s xfer;
  } eng_s;

endpackage

// file: core/byte_lane.sv
// Places one received byte on its lane of a 32-bit memory write.
`timescale 1ns/1ps
`default_nettype none

module byte_lane (
  input wire logic [1:0] lane,
  input wire logic [7:0] data_byte,
  output logic [31:0] wdata,
  output logic [3:0] wstrb
);

  // The byte is copied to all lanes; the strobe picks the one that lands.
  always_comb begin
    wdata = {4{data_byte}};
    wstrb = 4'(4'h1 << lane);
  end

endmodule
`default_nettype wire

// file: core/axil_slave.sv
// AXI4-Lite slave front end that turns bus writes into register strobes and returns read data.
`timescale 1ns/1ps
`default_nettype none

module axil_slave
  import usb_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] rd_data,
  output reg_wr_s reg_wr
);

  axil_s s_reg;
  axil_s s_next;

  // Address and data are taken in either order; the strobe fires once both are held.
  always_comb begin
    s_next = s_reg;
    s_next.wr.valid = 1'b0;
    if (s_axi_awvalid && s_reg.aw_rdy) begin
      s_next.aw_rdy = 1'b0;
      s_next.wr.addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.w_rdy) begin
      s_next.w_rdy = 1'b0;
      s_next.wr.data = s_axi_wdata;
      s_next.wr.strb = s_axi_wstrb;
    end
    if (!s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.bvalid) begin
      s_next.wr.valid = 1'b1;
      s_next.bvalid = 1'b1;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
      s_next.aw_rdy = 1'b1;
      s_next.w_rdy = 1'b1;
    end
    // Reads have no side effect, so the data is caught on the address handshake.
    if (s_axi_arvalid && s_reg.ar_rdy) begin
      s_next.ar_rdy = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_data;
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
      s_next.ar_rdy = 1'b1;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.aw_rdy <= 1'b1;
      s_reg.w_rdy <= 1'b1;
      s_reg.ar_rdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Unmapped offsets still answer OKAY; they read as zero and ignore writes.
  assign s_axi_awready = s_reg.aw_rdy;
  assign s_axi_wready = s_reg.w_rdy;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = s_reg.ar_rdy;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = 2'h0;
  assign reg_wr = s_reg.wr;

endmodule
`default_nettype wire

// file: tb/mem_model.sv
// Main memory partner that answers engine word requests after a random wait.
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import usb_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire mem_req_s mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [256];
  logic [1:0] dly;
  // Read data is noise outside the ack cycle, so a late sample never looks right by chance.
  always @(posedge clk) begin
    mem_ack <= 1'h0;
    mem_rdata <= $urandom;
    if (!rst_n) begin
      dly <= 2'h0;
    end else if (mem_req.valid && !mem_ack) begin
      if (dly == 2'h0) begin
        mem_ack <= 1'h1;
        dly <= 2'($urandom);
        mem_rdata <= mem[mem_req.addr[9:2]];
        for (int i = 0; i < 4; i++) begin
          if (mem_req.we && mem_req.wstrb[i]) begin
            mem[mem_req.addr[9:2]][8*i+:8] <= mem_req.wdata[8*i+:8];
          end
        end
      end else begin
        dly <= dly - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/usb_dma_engine_props.sv
// Port-level checks of the USB DMA engine.
`timescale 1ns/1ps
`default_nettype none
module usb_dma_engine_props
  import usb_dma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire mem_req_s mem_req,
  input wire logic mem_ack,
  input wire tx_xfer_s tx_xfer,
  input wire logic tx_done,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic tx_dma_irq
);
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_bresp; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
  a_bresp: assert property (p_bresp) else $error("write response not okay");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat) else $error("read data late");
  property p_mhold; mem_req.valid && !mem_ack |=> $stable(mem_req); endproperty
  a_mhold: assert property (p_mhold) else $error("memory request changed before ack");
  property p_lane; mem_req.valid && mem_req.we && mem_req.wstrb != 4'hF |-> mem_req.wstrb == 4'h1 << mem_req.addr[1:0]; endproperty
  a_lane: assert property (p_lane) else $error("byte strobe off its lane");
  property p_align; mem_req.valid && !mem_req.we |-> mem_req.addr[1:0] == 2'h0; endproperty
  a_align: assert property (p_align) else $error("descriptor read unaligned");
  property p_xhold; tx_xfer.valid && !tx_done |=> !tx_xfer.valid || $stable(tx_xfer); endproperty
  a_xhold: assert property (p_xhold) else $error("transmit buffer changed while pending");
  property p_rxone; rx_valid && rx_ready |=> !rx_ready; endproperty
  a_rxone: assert property (p_rxone) else $error("second byte taken before write");
  c_txirq: cover property ($rose(tx_dma_irq));
  c_rxbyte: cover property (rx_valid && rx_ready);
  c_tear: cover property (tx_xfer.valid && !tx_done ##1 !tx_xfer.valid);
endmodule
bind usb_dma_engine usb_dma_engine_props usb_dma_engine_props_i (.clk, .rst_n, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mem_req, .mem_ack, .tx_xfer, .tx_done,
  .rx_valid, .rx_ready, .tx_dma_irq);
`default_nettype wire

// file: tb/usb_dma_engine_tb.sv
// Self-checking bench for the USB DMA engine.
`timescale 1ns/1ps
`default_nettype none
`include "usb_dma_map.svh"
module usb_dma_engine_tb;
  import usb_dma_pkg::*;
  logic clk = '0, rst_n = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, tx_done = '0, rx_valid = '0, rx_last = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rx_byte = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, mem_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic rx_ready, tx_dma_irq, rx_dma_irq, mem_ack;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mem_req_s mem_req;
  tx_xfer_s tx_xfer;
  logic [31:0] exp_q[$];
  int fail_count = 0, n_checks = 0;
  logic [15:0] len;
  logic [7:0] b [5];
  always #10 clk = ~clk;
  usb_dma_engine usb_dma_engine_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req,
    .mem_ack, .mem_rdata, .tx_xfer, .tx_done, .rx_valid, .rx_byte, .rx_last, .rx_ready, .tx_dma_irq, .rx_dma_irq);
  mem_model mem_model_i (.clk, .rst_n, .mem_req, .mem_ack, .mem_rdata);
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Address and data are offered together and each is released once taken.
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
  endtask
  // The expected word is queued; the monitor below compares it on arrival.
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
  endtask
  always @(posedge clk)
    if (s_axi_rvalid && s_axi_rready) chk(s_axi_rdata, exp_q.pop_front());
  task dsc(input int a, input logic [31:0] w0, w1, w2, w3);
    mem_model_i.mem[a/4] = w0;
    mem_model_i.mem[a/4+1] = w1;
    mem_model_i.mem[a/4+2] = w2;
    mem_model_i.mem[a/4+3] = w3;
  endtask
  function automatic logic [31:0] m(input int a);
    return mem_model_i.mem[a/4];
  endfunction
  // Watchdog cuts a hang short after about 50,000 cycles.
  initial begin
    #1000000;
    fail_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(87000));
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`REG_TEARDOWN_OFS, 32'h80000000);
    rd(`REG_STATUS_OFS, 32'h00000000);
    $display("test reset done");
    len = 16'($urandom_range(64, 1));
    dsc(32'h40, 32'h0, 32'h200, {16'h3, len}, {4'hE, 12'h0, len});
    wr(`REG_CTRL_OFS, 32'h1);
    wr(`REG_TX_HEAD_OFS, 32'h40);
    while (!tx_xfer.valid) @(posedge clk);
    chk(tx_xfer.addr, 32'h203);
    chk(32'(tx_xfer.len), 32'(len));
    tx_done <= 1'h1;
    @(posedge clk);
    tx_done <= 1'h0;
    while (!tx_dma_irq) @(posedge clk);
    rd(`REG_TX_COMP_OFS, 32'h40);
    chk(m(32'h4C), {4'hD, 12'h0, len});
    wr(`REG_TX_COMP_OFS, 32'h40);
    rd(`REG_STATUS_OFS, 32'h00000000);
    $display("test tx done");
    dsc(32'h50, 32'h0, 32'h220, {16'h0, len}, {4'hE, 12'h0, len});
    wr(`REG_TX_HEAD_OFS, 32'h50);
    while (!tx_xfer.valid) @(posedge clk);
    wr(`REG_TEARDOWN_OFS, 32'h1);
    chk(32'(tx_xfer.valid), 32'h1);
    wr(`REG_TEARDOWN_OFS, 32'h0);
    while (!tx_dma_irq) @(posedge clk);
    chk(32'(tx_xfer.valid), 32'h0);
    rd(`REG_TX_COMP_OFS, 32'h0FFFFFFC);
    rd(`REG_TX_HEAD_OFS, 32'h0);
    rd(`REG_TEARDOWN_OFS, 32'h80000000);
    $display("test teardown done");
    dsc(32'h80, 32'h90, 32'h300, 32'h4, 32'h0);
    dsc(32'h90, 32'h0, 32'h310, 32'h8, 32'h0);
    wr(`REG_RX_OFFSET_OFS, 32'h2);
    wr(`REG_RX_HEAD_OFS, 32'h80);
    wr(`REG_CTRL_OFS, 32'h3);
    rx_valid <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      if (i == 1) begin
        rx_valid <= 1'h0;
        wr(`REG_TEARDOWN_OFS, 32'h0);
        rd(`REG_TEARDOWN_OFS, 32'h0);
        rx_valid <= 1'h1;
      end
      b[i] = 8'($urandom);
      rx_byte <= b[i];
      rx_last <= (i == 4);
      do @(posedge clk); while (!rx_ready);
    end
    rx_valid <= 1'h0;
    while (!rx_dma_irq) @(posedge clk);
    rd(`REG_RX_COMP_OFS, 32'h90);
    chk(m(32'h88), 32'h00020002);
    chk(m(32'h98), 32'h00000003);
    chk(m(32'h8C), 32'h80000005);
    chk(m(32'h9C) >> 28, 32'h5);
    chk(32'(m(32'h300) >> 16), {16'h0, b[1], b[0]});
    chk(32'(m(32'h310) & 32'h00FFFFFF), {8'h0, b[4], b[3], b[2]});
    rd(`REG_TEARDOWN_OFS, 32'h80000000);
    wr(`REG_RX_COMP_OFS, 32'h90);
    rd(`REG_STATUS_OFS, 32'h00000001);
    $display("test rx done");
    report_and_stop;
  end
endmodule
`default_nettype wire
